//--- design/ppi_parity.sv
// Shared constants for the primary PCI port and its even-parity generator.
package ppi_pkg;

    // Bus widths of the multiplexed address/data and command/enable lines.
    localparam int AD_W            = 32;
    localparam int CBE_W           = 4;
    // Supported primary bus clock range, in MHz.
    localparam int PCI_MIN_MHZ     = 33;
    localparam int PCI_MAX_MHZ     = 66;
    // Number of flip-flops every pin input passes before logic reads it.
    localparam int SYNC_DEPTH      = 2;
    // Clocks a sustained line is driven high before it is released.
    localparam int STS_HIGH_CYCLES = 1;
    // Clocks by which the parity line trails the address/data lines.
    localparam int PAR_LAG         = 1;
    // Command bit that tells a write (set) from a read (clear).
    localparam int CMD_WR_BIT      = 0;
    // Width of the whole synchronised pin bundle.
    localparam int PIN_W           = AD_W + CBE_W + 5;
    // Values driven onto the lines while the bus is parked.
    localparam logic [AD_W-1:0]  PARK_AD  = 32'h0000_0000;
    localparam logic [CBE_W-1:0] PARK_CBE = 4'h0;

    // Initiator sequence states.
    typedef enum logic [2:0] {
        M_IDLE = 3'h0,
        M_ADDR = 3'h1,
        M_LOAD = 3'h2,
        M_DATA = 3'h3,
        M_TURN = 3'h4
    } ppi_mst_e;

    // Target sequence states.
    typedef enum logic [1:0] {
        T_IDLE  = 2'h0,
        T_LOAD  = 2'h1,
        T_DRIVE = 2'h2,
        T_TURN  = 2'h3
    } ppi_tgt_e;

endpackage : ppi_pkg

`timescale 1ns/10ps

// Even parity over one address/data word and its command/enable nibble.
module ppi_parity
    import ppi_pkg::*;
(
    input  wire logic [AD_W-1:0]  data,
    input  wire logic [CBE_W-1:0] cbe,
    output wire logic             par
);

    // The xor of all bits is the bit that makes the total count even.
    assign par = ^{data, cbe};

endmodule : ppi_parity

//--- design/ppi_primary_if.sv
// Primary-side PCI port: initiator, target, parking and parity.
// What this block does
// - 32-bit port, all transfers on one clock
// - Address on AD in the first clock of FRAME asserted
// - Data moves only when both readies low
// - Command in address phase, enables after
// - Park AD, enables, parity while granted idle
// - Parity makes ones count even
// - Address/write parity checked one clock later
// - Read parity driven one clock after TRDY
// - Parity released one clock after AD
// - FRAME high marks the final data phase
// - Sustained lines driven high before release
// - Asserted ready held until phase completes
`timescale 1ns/10ps

module ppi_primary_if
    import ppi_pkg::*;
#(
    parameter int CNT_W = 8  // Width of the burst word count.
)(
    input  wire logic              ref_clk,
    input  wire logic              reset,
    // Primary bus pins, each but grant split into in, out and low-true enable.
    input  wire logic [AD_W-1:0]   primary_address_data_in,
    output logic      [AD_W-1:0]   primary_address_data_out,
    output logic                   primary_address_data_oe_n,
    input  wire logic [CBE_W-1:0]  primary_command_byte_enables_in,
    output logic      [CBE_W-1:0]  primary_command_byte_enables_out,
    output logic                   primary_command_byte_enables_oe_n,
    input  wire logic              primary_parity_bit_in,
    output logic                   primary_parity_bit_out,
    output logic                   primary_parity_bit_oe_n,
    input  wire logic              primary_frame_n_in,
    output logic                   primary_frame_n_out,
    output logic                   primary_frame_n_oe_n,
    input  wire logic              primary_initiator_ready_n_in,
    output logic                   primary_initiator_ready_n_out,
    output logic                   primary_initiator_ready_n_oe_n,
    input  wire logic              primary_target_ready_n_in,
    output logic                   primary_target_ready_n_out,
    output logic                   primary_target_ready_n_oe_n,
    input  wire logic              primary_grant_n,
    // Initiator request side.
    input  wire logic              mst_req,
    output logic                   mst_req_ready,
    input  wire logic [3:0]        mst_cmd,
    input  wire logic [AD_W-1:0]   mst_addr,
    input  wire logic [CBE_W-1:0]  mst_be,
    input  wire logic [CNT_W-1:0]  mst_count,
    input  wire logic              mst_wr_valid,
    output logic                   mst_wr_ready,
    input  wire logic [AD_W-1:0]   mst_wr_data,
    output logic                   mst_rd_valid,
    output logic      [AD_W-1:0]   mst_rd_data,
    // Target side.
    output logic                   tgt_addr_valid,
    output logic      [AD_W-1:0]   tgt_addr,
    output logic      [3:0]        tgt_cmd,
    input  wire logic              tgt_claim,
    input  wire logic              tgt_rd_valid,
    output logic                   tgt_rd_ready,
    input  wire logic [AD_W-1:0]   tgt_rd_data,
    output logic                   tgt_wr_valid,
    output logic      [AD_W-1:0]   tgt_wr_data,
    output logic      [CBE_W-1:0]  tgt_wr_be,
    // Parity error pulses, one clock long.
    output logic                   addr_par_err,
    output logic                   data_par_err
);

    // A zero-width counter cannot hold a burst length.
    if (CNT_W < 1 || CNT_W > 16) begin : g_bad_cnt
        $error("ppi_primary_if: CNT_W must lie in 1..16");
    end

    logic [PIN_W-1:0] sync1_q;        // First stage, read only by stage two.
    logic [PIN_W-1:0] sync2_q;        // Settled pin values.
    wire  [AD_W-1:0]  ad_s    = sync2_q[PIN_W-1 -: AD_W];
    wire  [CBE_W-1:0] cbe_s   = sync2_q[5 +: CBE_W];
    wire              par_s   = sync2_q[4];
    wire              frame_s = sync2_q[3];
    wire              irdy_s  = sync2_q[2];
    wire              trdy_s  = sync2_q[1];
    wire              gnt_s   = sync2_q[0];

    // Every pin passes two flops; the whole port then runs on ref_clk.
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            sync1_q <= '1;
            sync2_q <= '1;
        end else begin
            sync1_q <= {primary_address_data_in,
                        primary_command_byte_enables_in,
                        primary_parity_bit_in, primary_frame_n_in,
                        primary_initiator_ready_n_in,
                        primary_target_ready_n_in, primary_grant_n};
            sync2_q <= sync1_q;
        end
    end

    ppi_mst_e         m_state_q;      // Initiator state.
    logic [CNT_W-1:0] m_cnt_q;        // Data phases still to run.
    logic [AD_W-1:0]  m_addr_q;       // Captured start address.
    logic [3:0]       m_cmd_q;        // Captured bus command.
    logic [CBE_W-1:0] m_be_q;         // Byte enables for every phase.
    logic [AD_W-1:0]  m_wdata_q;      // Write word on the bus.
    logic             m_write_q;      // Burst is a write.
    ppi_tgt_e         t_state_q;      // Target state.
    logic             t_write_q;      // Claimed access is a write.
    logic [AD_W-1:0]  t_ad_q;         // Read word driven as target.
    logic             frame_prev_q;   // Settled FRAME one clock ago.
    logic [1:0]       own_frame_q;    // Our FRAME drive, aged to match.
    logic [1:0]       own_ad_q;       // Our AD drive, aged to match.
    logic             chk_addr_q;     // Address parity due this clock.
    logic             chk_data_q;     // Data parity due this clock.
    logic             exp_par_q;      // Parity expected from the bus.
    logic             par_q;          // Driven parity bit.
    logic             par_oe_n_q;     // Parity enable, trails AD.

    wire bus_idle   = frame_s & irdy_s;
    wire m_last     = (m_cnt_q == CNT_W'(1));
    wire m_start    = (m_state_q == M_IDLE) & (t_state_q == T_IDLE) & mst_req
                    & ~gnt_s & bus_idle & (mst_count != '0);
    wire m_in_data  = (m_state_q == M_LOAD) | (m_state_q == M_DATA);
    wire m_xfer     = (m_state_q == M_DATA) & ~trdy_s;
    wire t_xfer     = (t_state_q == T_DRIVE) & ~irdy_s;
    wire xfer_s     = ~irdy_s & ~trdy_s;
    wire addr_phase = ~frame_s & frame_prev_q & ~own_frame_q[1];
    wire park       = (m_state_q == M_IDLE) & (t_state_q == T_IDLE)
                    & ~gnt_s & bus_idle;

    // Drive decodes for each line group.
    wire m_ad_drv   = (m_state_q == M_ADDR) | (m_write_q & m_in_data);
    wire m_cbe_drv  = (m_state_q == M_ADDR) | m_in_data;
    wire t_ad_drv   = ~t_write_q & ((t_state_q == T_LOAD)
                    | (t_state_q == T_DRIVE));
    wire [CBE_W-1:0] cbe_bus = primary_command_byte_enables_oe_n ? cbe_s
                             : primary_command_byte_enables_out;
    wire par_gen;                     // Parity of what we drive now.
    wire par_chk;                     // Parity of what the bus carried.

    assign mst_req_ready = (m_state_q == M_IDLE);
    assign mst_wr_ready  = (m_state_q == M_LOAD) & m_write_q;
    assign tgt_rd_ready  = (t_state_q == T_LOAD);

    // Address and command only in the address phase, enables after it.
    assign primary_address_data_oe_n = ~(m_ad_drv | t_ad_drv | park);
    assign primary_address_data_out  =
        (m_state_q == M_ADDR) ? m_addr_q :
        m_ad_drv ? m_wdata_q : t_ad_drv ? t_ad_q : PARK_AD;
    assign primary_command_byte_enables_oe_n = ~(m_cbe_drv | park);
    assign primary_command_byte_enables_out  =
        (m_state_q == M_ADDR) ? m_cmd_q :
        m_cbe_drv ? m_be_q : PARK_CBE;
    // FRAME is low through the access and high in the last phase.
    assign primary_frame_n_oe_n = ~((m_state_q == M_ADDR) | m_in_data);
    assign primary_frame_n_out  = (m_state_q != M_ADDR) & (~m_in_data
                                | m_last);
    // IRDY stays driven, high, in the turn clock before release.
    assign primary_initiator_ready_n_oe_n = ~(m_in_data
                                          | (m_state_q == M_TURN));
    assign primary_initiator_ready_n_out  = (m_state_q != M_DATA);
    assign primary_target_ready_n_oe_n    = (t_state_q == T_IDLE);
    assign primary_target_ready_n_out     = (t_state_q != T_DRIVE);
    assign primary_parity_bit_out         = par_q;
    assign primary_parity_bit_oe_n        = par_oe_n_q;

    ppi_parity u_par_gen (
        .data (primary_address_data_out),
        .cbe  (cbe_bus),
        .par  (par_gen)
    );

    ppi_parity u_par_chk (
        .data (ad_s),
        .cbe  (cbe_s),
        .par  (par_chk)
    );

    // Initiator sequence: address, then load and data phases in turn.
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            m_state_q    <= M_IDLE;
            m_cnt_q      <= '0;
            m_addr_q     <= '0;
            m_cmd_q      <= '0;
            m_be_q       <= '0;
            m_wdata_q    <= '0;
            m_write_q    <= 1'b0;
            mst_rd_valid <= 1'b0;
            mst_rd_data  <= '0;
        end else begin
            mst_rd_valid <= m_xfer & ~m_write_q;
            if (m_xfer & ~m_write_q) begin
                mst_rd_data <= ad_s;
            end
            case (m_state_q)
                M_IDLE: begin
                    if (m_start) begin
                        m_state_q <= M_ADDR;
                        m_cnt_q   <= mst_count;
                        m_addr_q  <= mst_addr;
                        m_cmd_q   <= mst_cmd;
                        m_be_q    <= mst_be;
                        m_write_q <= mst_cmd[CMD_WR_BIT];
                    end
                end
                M_ADDR: begin
                    m_state_q <= M_LOAD;
                end
                M_LOAD: begin
                    // Reads need no word; writes wait for one.
                    if (~m_write_q | mst_wr_valid) begin
                        m_wdata_q <= mst_wr_data;
                        m_state_q <= M_DATA;
                    end
                end
                M_DATA: begin
                    // IRDY holds low until the target answers.
                    if (m_xfer) begin
                        m_cnt_q   <= m_cnt_q - CNT_W'(1);
                        m_state_q <= m_last ? M_TURN : M_LOAD;
                    end
                end
                M_TURN: begin
                    m_state_q <= M_IDLE;
                end
                default: begin
                    m_state_q <= M_IDLE;
                end
            endcase
        end
    end

    // Target sequence; the user decodes the address and claims it.
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            t_state_q    <= T_IDLE;
            t_write_q    <= 1'b0;
            t_ad_q       <= '0;
            tgt_wr_valid <= 1'b0;
            tgt_wr_data  <= '0;
            tgt_wr_be    <= '0;
        end else begin
            tgt_wr_valid <= t_xfer & t_write_q;
            if (t_xfer & t_write_q) begin
                tgt_wr_data <= ad_s;
                tgt_wr_be   <= cbe_s;
            end
            case (t_state_q)
                T_IDLE: begin
                    if (tgt_addr_valid & tgt_claim) begin
                        t_write_q <= tgt_cmd[CMD_WR_BIT];
                        t_state_q <= tgt_cmd[CMD_WR_BIT] ? T_DRIVE : T_LOAD;
                    end
                end
                T_LOAD: begin
                    if (tgt_rd_valid) begin
                        t_ad_q    <= tgt_rd_data;
                        t_state_q <= T_DRIVE;
                    end
                end
                T_DRIVE: begin
                    // TRDY holds low until the initiator is ready too.
                    if (t_xfer) begin
                        t_state_q <= frame_s ? T_TURN
                                   : (t_write_q ? T_DRIVE : T_LOAD);
                    end
                end
                T_TURN: begin
                    t_state_q <= T_IDLE;
                end
                default: begin
                    t_state_q <= T_IDLE;
                end
            endcase
        end
    end

    // Address capture, ownership history and the parity checker.
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            frame_prev_q   <= 1'b1;
            own_frame_q    <= '0;
            own_ad_q       <= '0;
            tgt_addr_valid <= 1'b0;
            tgt_addr       <= '0;
            tgt_cmd        <= '0;
            chk_addr_q     <= 1'b0;
            chk_data_q     <= 1'b0;
            exp_par_q      <= 1'b0;
            addr_par_err   <= 1'b0;
            data_par_err   <= 1'b0;
        end else begin
            frame_prev_q   <= frame_s;
            own_frame_q    <= {own_frame_q[0], ~primary_frame_n_oe_n};
            own_ad_q       <= {own_ad_q[0], ~primary_address_data_oe_n};
            tgt_addr_valid <= addr_phase;
            if (addr_phase) begin
                tgt_addr <= ad_s;
                tgt_cmd  <= cbe_s;
            end
            // The bus parity bit arrives one clock after its word.
            chk_addr_q   <= addr_phase;
            chk_data_q   <= xfer_s & ~own_ad_q[1];
            exp_par_q    <= par_chk;
            addr_par_err <= chk_addr_q & (par_s != exp_par_q);
            data_par_err <= chk_data_q & (par_s != exp_par_q);
        end
    end

    // Parity follows its word by one clock, enable included.
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            par_q      <= 1'b0;
            par_oe_n_q <= 1'b1;
        end else begin
            par_q      <= par_gen;
            par_oe_n_q <= primary_address_data_oe_n;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    chk_par_release: assert property (
        primary_parity_bit_oe_n == $past(primary_address_data_oe_n))
        else $error("parity enable does not trail AD enable");
    chk_par_even: assert property (
        !primary_parity_bit_oe_n |-> ((^{$past(primary_address_data_out),
            $past(cbe_bus)}) == primary_parity_bit_out))
        else $error("driven parity is not even");
    chk_read_par: assert property (
        (t_state_q == T_DRIVE && !t_write_q) |=> !primary_parity_bit_oe_n)
        else $error("read parity not driven after TRDY");
    chk_frame_release: assert property (
        $rose(primary_frame_n_oe_n) |-> $past(primary_frame_n_out))
        else $error("FRAME released without a high clock");
    chk_irdy_release: assert property (
        $rose(primary_initiator_ready_n_oe_n)
        |-> $past(primary_initiator_ready_n_out, 1))
        else $error("IRDY released without a high clock");
    chk_irdy_hold: assert property (
        (!primary_initiator_ready_n_out && trdy_s)
        |=> !primary_initiator_ready_n_out)
        else $error("IRDY dropped before the phase ended");
    chk_trdy_hold: assert property (
        (!primary_target_ready_n_out && irdy_s)
        |=> !primary_target_ready_n_out)
        else $error("TRDY dropped before the phase ended");
    chk_addr_phase: assert property (
        (m_state_q == M_ADDR) |-> (!primary_frame_n_out
        && primary_address_data_out == m_addr_q
        && primary_command_byte_enables_out == m_cmd_q)
        ##1 primary_command_byte_enables_out == m_be_q)
        else $error("address phase lines wrong");
    chk_frame_last: assert property (
        (m_state_q == M_DATA) |-> (primary_frame_n_out == m_last))
        else $error("FRAME does not mark the last phase");
    chk_park_lines: assert property (
        park |-> (!primary_address_data_oe_n
        && !primary_command_byte_enables_oe_n) ##1 !primary_parity_bit_oe_n)
        else $error("bus not parked while granted");
    chk_xfer_both: assert property (
        mst_rd_valid |-> (!$past(trdy_s) && $past(m_state_q) == M_DATA))
        else $error("read word taken without both readies");

    cov_mst_write: cover property (m_state_q == M_TURN && m_write_q);
    cov_mst_read:  cover property (mst_rd_valid ##1 m_state_q == M_TURN);
    cov_tgt_read:  cover property (t_state_q == T_DRIVE && !t_write_q);
    cov_park:      cover property (park);
    cov_par_err:   cover property (addr_par_err || data_par_err);

endmodule : ppi_primary_if

//--- test/ppi_bus_model.sv
// Far-side agent of the primary bus, answering the port's bursts as target.
`timescale 1ns/10ps

module ppi_bus_model
    import ppi_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              reset,
    input  wire logic [AD_W-1:0]   ad,
    input  wire logic [CBE_W-1:0]  cbe,
    input  wire logic              frame_n,
    input  wire logic              irdy_n,
    input  wire logic              bad_par,
    output logic      [AD_W-1:0]   ad_drv,
    output logic                   ad_oe_n,
    output logic                   par_drv,
    output logic                   par_oe_n,
    output logic                   trdy_drv,
    output logic                   trdy_oe_n,
    output logic                   obs_valid,
    output logic      [35:0]       obs_word
);
    logic [AD_W-1:0] rd_q[$];   // Read words queued by the bench.
    logic            frame_q;   // Bus frame one clock ago.
    logic            rd;        // Current burst is a read.
    logic            act;       // A burst is in progress.
    logic            fin;       // Last word moved; release next clock.
    int              wt;        // Clocks still to stall before answering.
    int              mseed = 48;

    // One word per ready pulse, then a stall of random length, so the
    // port sees both prompt and slow answers through its input sync.
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            {ad_oe_n, par_oe_n, trdy_oe_n, trdy_drv, frame_q} <= 5'h1f;
            {obs_valid, act, fin, rd, par_drv} <= 5'h00;
            ad_drv <= 32'h0000_0000;
            obs_word <= 36'h0_0000_0000;
            wt <= 0;
        end else begin
            obs_valid <= 1'b0;
            frame_q <= frame_n;
            par_drv <= ^{ad, cbe} ^ bad_par;
            par_oe_n <= ad_oe_n;
            if (!frame_n && frame_q && irdy_n && !act) begin
                // Address clock: note command and address.
                obs_valid <= 1'b1;
                obs_word <= {cbe, ad};
                rd <= ~cbe[CMD_WR_BIT];
                act <= 1'b1;
                wt <= 2;
            end else if (fin) begin
                // Ready was driven high for a clock; now let go.
                {trdy_oe_n, ad_oe_n, act, fin} <= 4'hc;
            end else if (!trdy_oe_n && !trdy_drv && !irdy_n) begin
                // Both readies low: one word moves.
                obs_valid <= !rd;
                obs_word <= {cbe, ad};
                trdy_drv <= 1'b1;
                fin <= frame_n;
                wt <= 3 + ($unsigned($random(mseed)) % 4);
            end else if (wt != 0) begin
                wt <= wt - 1;
            end else if (act && !irdy_n && trdy_drv) begin
                // Held low until the word moves.
                trdy_oe_n <= 1'b0;
                trdy_drv <= 1'b0;
                if (rd) begin
                    ad_oe_n <= 1'b0;
                    ad_drv <= rd_q.pop_front();
                end
            end
        end
    end
endmodule : ppi_bus_model

//--- test/tb.sv
// Self-checking bench for the primary bus port and its far-side target.
`timescale 1ns/10ps

module tb;
    import ppi_pkg::*;
    logic            ref_clk = 1'b0;
    logic            reset = 1'b1;
    logic [AD_W-1:0] ad, ad_o, m_ad, mst_addr, mst_wr_data, mst_rd_data, p_ad;
    logic [AD_W-1:0] flt = 32'h5a5a_a5a5;   // Released lines, new each clock.
    logic [3:0]      cbe, cbe_o, mst_cmd, mst_be, primary_command_byte_enables;
    logic [7:0]      mst_count;
    logic [1:0]      p_fr, p_ir;
    logic            par, par_o, par_oe, m_par, m_par_oe, ad_oe, cbe_oe, p_adoe;
    logic            fr, fr_o, fr_oe, ir, ir_o, ir_oe, tr, tr_o, tr_oe;
    logic            m_ad_oe, m_tr, m_tr_oe, obs_v, bad_par, gnt_n, tav;
    logic            mst_req, mst_req_ready, mst_wr_valid, mst_wr_ready;
    logic            mst_rd_valid, addr_par_err, data_par_err;
    logic [35:0]     obs_w;
    logic [39:0]     exp_q[$];   // Expected bus notes and read words.
    int              n_mismatch = 0, checked = 0, cyc = 0, seed = 48;
    int              n_perr = 0, n_aerr = 0, exp_perr = 0;

    // Wire resolution: sustained lines have pull-ups.
    assign ad = !ad_oe ? ad_o : !m_ad_oe ? m_ad : flt;
    assign cbe = !cbe_oe ? cbe_o : flt[3:0];
    assign par = !par_oe ? par_o : !m_par_oe ? m_par : flt[0];
    assign fr = fr_oe | fr_o;
    assign ir = ir_oe | ir_o;
    assign tr = (tr_oe | tr_o) & (m_tr_oe | m_tr);

    always #2 ref_clk = ~ref_clk;

    ppi_primary_if u_dut (
        .ref_clk(ref_clk), .reset(reset),
        .primary_address_data_in(ad), .primary_address_data_out(ad_o),
        .primary_address_data_oe_n(ad_oe),
        .primary_command_byte_enables_in(cbe),
        .primary_command_byte_enables_out(cbe_o),
        .primary_command_byte_enables_oe_n(cbe_oe),
        .primary_parity_bit_in(par), .primary_parity_bit_out(par_o),
        .primary_parity_bit_oe_n(par_oe), .primary_frame_n_in(fr),
        .primary_frame_n_out(fr_o), .primary_frame_n_oe_n(fr_oe),
        .primary_initiator_ready_n_in(ir), .primary_initiator_ready_n_out(ir_o),
        .primary_initiator_ready_n_oe_n(ir_oe), .primary_target_ready_n_in(tr),
        .primary_target_ready_n_out(tr_o), .primary_target_ready_n_oe_n(tr_oe),
        .primary_grant_n(gnt_n), .mst_req(mst_req),
        .mst_req_ready(mst_req_ready), .mst_cmd(mst_cmd), .mst_addr(mst_addr),
        .mst_be(mst_be), .mst_count(mst_count), .mst_wr_valid(mst_wr_valid),
        .mst_wr_ready(mst_wr_ready), .mst_wr_data(mst_wr_data),
        .mst_rd_valid(mst_rd_valid), .mst_rd_data(mst_rd_data),
        .tgt_addr_valid(tav), .tgt_addr(), .tgt_cmd(), .tgt_claim(1'b0),
        .tgt_rd_valid(1'b0), .tgt_rd_ready(), .tgt_rd_data(32'h0000_0000),
        .tgt_wr_valid(), .tgt_wr_data(), .tgt_wr_be(),
        .addr_par_err(addr_par_err), .data_par_err(data_par_err));

    ppi_bus_model u_bus (
        .ref_clk(ref_clk), .reset(reset), .ad(ad), .cbe(cbe), .frame_n(fr),
        .irdy_n(ir), .bad_par(bad_par), .ad_drv(m_ad), .ad_oe_n(m_ad_oe),
        .par_drv(m_par), .par_oe_n(m_par_oe), .trdy_drv(m_tr),
        .trdy_oe_n(m_tr_oe), .obs_valid(obs_v), .obs_word(obs_w));

    // Prints the verdict and ends the run.
    task automatic complete_run();
        if (n_mismatch == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run

    // Compares one value and reports a difference at once.
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    // Oldest note; an empty queue yields unknowns, so an extra word fails.
    function automatic logic [39:0] nxt();
        return exp_q.size() ? exp_q.pop_front() : 40'hx;
    endfunction : nxt

    // Wire watcher: parity lag, release order and the result queue.
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        flt <= ~flt;
        {p_ad, primary_command_byte_enables, p_adoe} <= {ad, cbe, ad_oe};
        {p_fr, p_ir} <= {fr_oe, fr_o, ir_oe, ir_o};
        if (cyc > 12) begin
            check(par_oe, p_adoe);
            if (!par_oe) check(par_o, ^{p_ad, primary_command_byte_enables});
            if (fr_oe && !p_fr[1]) check(p_fr[0], 1'b1);
            if (ir_oe && !p_ir[1]) check(p_ir[0], 1'b1);
            check(tav, 1'b0);
        end
        if (obs_v) check(obs_w, nxt());
        if (mst_rd_valid) check(mst_rd_data, nxt());
        n_perr <= n_perr + data_par_err;
        n_aerr <= n_aerr + addr_par_err;
        if (cyc == 30000) begin
            n_mismatch++;
            complete_run();
        end
    end

    // One burst of n words; the notes are queued before the request.
    task automatic burst(input logic wr, input int n, input logic bad);
        logic [AD_W-1:0] a, w;
        logic [3:0]      c, be;
        logic [AD_W-1:0] wq[$];
        int              t;
        a = $random(seed);
        be = 4'($random(seed));
        c = {3'($random(seed)), wr};
        exp_q.push_back({4'h0, c, a});
        for (int k = 0; k < n; k++) begin
            w = $random(seed);
            if (wr) wq.push_back(w);
            else u_bus.rd_q.push_back(w);
            exp_q.push_back({4'h0, wr ? be : 4'h0, w});
        end
        exp_perr += bad ? n : 0;
        {mst_cmd, mst_addr, mst_be, bad_par} <= {c, a, be, bad};
        mst_count <= 8'(n);
        mst_req <= 1'b1;
        t = 0;
        do @(posedge ref_clk); while (mst_req_ready && ++t < 200);
        mst_req <= 1'b0;
        for (int k = 0; k < n && wr; k++) begin
            mst_wr_valid <= 1'b1;
            mst_wr_data <= wq.pop_front();
            t = 0;
            do @(posedge ref_clk); while (!mst_wr_ready && ++t < 200);
        end
        mst_wr_valid <= 1'b0;
        t = 0;
        do @(posedge ref_clk); while (!mst_req_ready && ++t < 3000);
        bad_par <= 1'b0;
    endtask : burst

    initial begin
        {mst_req, mst_wr_valid, bad_par, gnt_n, mst_count} = 12'h000;
        {mst_cmd, mst_be, mst_addr, mst_wr_data} = 72'h0;
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (6) @(posedge ref_clk);
        // Idle with grant: lines parked at zero, parity driven even.
        check({ad_oe, cbe_oe, par_oe, ad_o, cbe_o, par_o}, 40'h0);
        // No grant, then a zero count: the port must stay off the bus.
        mst_req <= 1'b1;
        for (int k = 0; k < 16; k++) begin
            gnt_n <= (k < 8);
            @(posedge ref_clk);
            check(fr_oe, 1'b1);
        end
        mst_req <= 1'b0;
        for (int k = 0; k < 24; k++) begin
            burst(k[0], 1 + $unsigned($random(seed)) % 4, 1'b0);
        end
        burst(1'b0, 1, 1'b1);
        burst(1'b1, 255, 1'b0);
        burst(1'b0, 40, 1'b0);
        repeat (20) @(posedge ref_clk);
        check(exp_q.size(), 0);
        check(n_perr, exp_perr);
        check(n_aerr, 0);
        complete_run();
    end
endmodule : tb
